// ==== design/dsl_pkg.sv ====
package dsl_pkg;

  // Word layout
  localparam int WORD_W      = 16;
  localparam int CODE_W      = 12;
  localparam int MODE_W      = 2;
  localparam int CNT_W       = 5;
  localparam int MODE_HI_POS = 13;
  localparam int MODE_LO_POS = 12;
  localparam int CODE_MSB    = 11;
  localparam int CODE_LSB    = 0;
  localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h10;
  localparam logic [CNT_W-1:0] LAST_BIT_IDX  = 5'h0F;

  // Values after reset
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;

  // Power mode field encodings
  localparam logic [MODE_W-1:0] MODE_NORMAL = 2'h0;
  localparam logic [MODE_W-1:0] MODE_PD_1K   = 2'h1;
  localparam logic [MODE_W-1:0] MODE_PD_100K = 2'h2;
  localparam logic [MODE_W-1:0] MODE_PD_HIZ  = 2'h3;
  localparam logic [MODE_W-1:0] MODE_RESET   = MODE_NORMAL;

  // Timing, system clock at 200 MHz
  localparam int CLK_MHZ       = 200;
  localparam int SYNC_HIGH_NS  = 33;
  localparam int SCLK_MAX_MHZ  = 30;
  localparam int RECOV_5V_NS   = 2500;
  localparam int RECOV_3V_NS   = 5000;
  localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int SCLK_HALF_CYC =
    (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int RECOV_5V_CYC  = (RECOV_5V_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOV_3V_CYC  = (RECOV_3V_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOV_W       = 11;
  localparam int GAP_W         = 4;
  localparam int HALF_W        = 3;

  localparam logic [RECOV_W-1:0] RECOV_5V_LD = RECOV_W'(RECOV_5V_CYC);
  localparam logic [RECOV_W-1:0] RECOV_3V_LD = RECOV_W'(RECOV_3V_CYC);
  localparam logic [GAP_W-1:0]   GAP_LAST    = GAP_W'(SYNC_HIGH_CYC - 1);
  localparam logic [HALF_W-1:0]  HALF_LAST   = HALF_W'(SCLK_HALF_CYC - 1);

  typedef enum logic [2:0] {
    H_IDLE,
    H_GAP,
    H_CLK_HI,
    H_CLK_LO,
    H_END
  } dsl_host_state_t;

endpackage : dsl_pkg

// ==== design/dsl_link_if.sv ====
`timescale 1ns/1ps
interface dsl_link_if;
  logic sync_n;
  logic sclk;
  logic din;

  modport dev (
    input sync_n,
    input sclk,
    input din
  );

  modport host (
    output sync_n,
    output sclk,
    output din
  );
endinterface : dsl_link_if

// ==== design/dsl_host.sv ====
`timescale 1ns/1ps
module dsl_host (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   req_valid,
  input  wire logic [dsl_pkg::WORD_W-1:0] req_word,
  input  wire logic [dsl_pkg::CNT_W-1:0]  req_len,
  output logic                        req_ready,
  dsl_link_if.host                    lnk
);
  import dsl_pkg::*;

  dsl_host_state_t   state_r;
  logic              sync_n_r;
  logic              sclk_r;
  logic              din_r;
  logic              ready_r;
  logic [WORD_W-1:0] word_r;
  logic [CNT_W-1:0]  len_r;
  logic [CNT_W-1:0]  sent_r;
  logic [GAP_W-1:0]  gap_r;
  logic [HALF_W-1:0] half_r;

  // Lengths outside 1..16 fall back to a full word
  function automatic logic [CNT_W-1:0] fix_len(input logic [CNT_W-1:0] l);
    fix_len = (l == '0 || l > BITS_PER_WORD) ? BITS_PER_WORD : l;
  endfunction : fix_len

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r  <= H_IDLE;
      sync_n_r <= 1'b1;
      sclk_r   <= 1'b1;
      din_r    <= 1'b0;
      ready_r  <= 1'b1;
      word_r   <= '0;
      len_r    <= BITS_PER_WORD;
      sent_r   <= '0;
      gap_r    <= '0;
      half_r   <= '0;
    end else begin
      case (state_r)
        H_IDLE: begin
          if (req_valid && ready_r) begin
            word_r   <= req_word;
            len_r    <= fix_len(req_len);
            ready_r  <= 1'b0;
            sync_n_r <= 1'b1;
            gap_r    <= '0;
            state_r  <= H_GAP;
          end
        end
        H_GAP: begin
          if (gap_r == GAP_LAST) begin
            sync_n_r <= 1'b0;
            din_r    <= word_r[WORD_W-1];
            word_r   <= {word_r[WORD_W-2:0], 1'b0};
            sent_r   <= '0;
            half_r   <= '0;
            state_r  <= H_CLK_HI;
          end else begin
            gap_r <= gap_r + 1'b1;
          end
        end
        H_CLK_HI: begin
          if (half_r == HALF_LAST) begin
            sclk_r  <= 1'b0;
            sent_r  <= sent_r + 1'b1;
            half_r  <= '0;
            state_r <= H_CLK_LO;
          end else begin
            half_r <= half_r + 1'b1;
          end
        end
        H_CLK_LO: begin
          if (half_r == HALF_LAST) begin
            sclk_r <= 1'b1;
            half_r <= '0;
            if (sent_r == len_r) begin
              state_r <= H_END;
            end else begin
              din_r   <= word_r[WORD_W-1];
              word_r  <= {word_r[WORD_W-2:0], 1'b0};
              state_r <= H_CLK_HI;
            end
          end else begin
            half_r <= half_r + 1'b1;
          end
        end
        H_END: begin
          // Short frames are cut off; full ones idle low for low power
          if (len_r != BITS_PER_WORD) begin
            sync_n_r <= 1'b1;
          end else begin
            sync_n_r <= 1'b0;
          end
          ready_r <= 1'b1;
          state_r <= H_IDLE;
        end
        default: begin
          state_r  <= H_IDLE;
          sync_n_r <= 1'b1;
          sclk_r   <= 1'b1;
          ready_r  <= 1'b1;
        end
      endcase
    end
  end

  assign lnk.sync_n = sync_n_r;
  assign lnk.sclk   = sclk_r;
  assign lnk.din    = din_r;
  assign req_ready  = ready_r;

endmodule : dsl_host

// ==== design/dsl_dev.sv ====
`timescale 1ns/1ps
module dsl_dev (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    supply_low,
  dsl_link_if.dev                      lnk,
  output logic [dsl_pkg::CODE_W-1:0]   code_out,
  output logic [dsl_pkg::MODE_W-1:0]   mode_out,
  output logic                         amp_on,
  output logic                         term_1k,
  output logic                         term_100k,
  output logic                         out_hiz,
  output logic                         out_valid,
  output logic                         word_loaded
);
  import dsl_pkg::*;

  // Link side, clocked by the shift clock
  logic [WORD_W-1:0] shift_r;
  logic [CNT_W-1:0]  bit_cnt_r;
  logic [WORD_W-1:0] stage_r;
  logic              req_tgl_r;
  logic              last_edge;

  // System side
  logic              req_s1_r;
  logic              req_s2_r;
  logic              req_seen_r;
  logic              new_word;
  logic [CODE_W-1:0] code_r;
  logic [MODE_W-1:0] mode_r;
  logic [MODE_W-1:0] mode_nxt;
  logic              amp_on_r;
  logic              term_1k_r;
  logic              term_100k_r;
  logic              out_hiz_r;
  logic              out_valid_r;
  logic              loaded_r;
  logic [RECOV_W-1:0] recov_r;
  logic              supply_s1_r;
  logic              supply_s2_r;

  function automatic logic [CODE_W-1:0] word_code(
    input logic [WORD_W-1:0] w
  );
    word_code = w[CODE_MSB:CODE_LSB];
  endfunction : word_code

  function automatic logic [MODE_W-1:0] word_mode(
    input logic [WORD_W-1:0] w
  );
    word_mode = {w[MODE_HI_POS], w[MODE_LO_POS]};
  endfunction : word_mode

  // The sixteenth falling edge of a frame that is still selected
  assign last_edge = !lnk.sync_n && (bit_cnt_r == LAST_BIT_IDX);

  // Select high clears the frame without any clock: the link clock
  // may stand still while the host raises select.
  always_ff @(negedge lnk.sclk or posedge lnk.sync_n) begin
    if (lnk.sync_n) begin
      shift_r   <= '0;
      bit_cnt_r <= '0;
    end else if (bit_cnt_r != BITS_PER_WORD) begin
      shift_r   <= {shift_r[WORD_W-2:0], lnk.din};
      bit_cnt_r <= bit_cnt_r + 1'b1;
    end
    // Counter parked at 16 ignores further edges
  end

  // Separate copy so a select rise right after the last edge
  // cannot wipe the word before the system side takes it.
  always_ff @(negedge lnk.sclk) begin
    if (last_edge) begin
      stage_r <= {shift_r[WORD_W-2:0], lnk.din};
    end
  end

  // Power-on reset also clears the toggle; the link clock is
  // idle during power-up, so no edge races the release.
  always_ff @(negedge lnk.sclk or posedge rst) begin
    if (rst) begin
      req_tgl_r <= 1'b0;
    end else if (last_edge) begin
      req_tgl_r <= ~req_tgl_r;
    end
  end

  // Toggle crossing into the system clock
  always_ff @(posedge clk) begin
    if (rst) begin
      req_s1_r   <= 1'b0;
      req_s2_r   <= 1'b0;
      req_seen_r <= 1'b0;
    end else begin
      req_s1_r   <= req_tgl_r;
      req_s2_r   <= req_s1_r;
      req_seen_r <= req_s2_r;
    end
  end

  // Stage is stable here: a further update needs a full new frame
  assign new_word = req_s2_r != req_seen_r;

  assign mode_nxt = new_word ? word_mode(stage_r) : mode_r;

  // Code and mode registers
  always_ff @(posedge clk) begin
    if (rst) begin
      code_r <= CODE_RESET;
      mode_r <= MODE_RESET;
    end else if (new_word) begin
      // Bits 15 and 14 are never looked at
      code_r <= word_code(stage_r);
      mode_r <= word_mode(stage_r);
    end
  end

  // Output stage decode; taken from the next mode so the stage
  // switches in the same cycle as the mode register
  always_ff @(posedge clk) begin
    if (rst) begin
      amp_on_r    <= 1'b1;
      term_1k_r   <= 1'b0;
      term_100k_r <= 1'b0;
      out_hiz_r   <= 1'b0;
    end else begin
      amp_on_r    <= (mode_nxt == MODE_NORMAL);
      term_1k_r   <= (mode_nxt == MODE_PD_1K);
      term_100k_r <= (mode_nxt == MODE_PD_100K);
      out_hiz_r   <= (mode_nxt == MODE_PD_HIZ);
    end
  end

  // Supply strap comes from outside the clock domain; it only picks
  // the reload value, so two flops of delay cost nothing.
  always_ff @(posedge clk) begin
    if (rst) begin
      supply_s1_r <= 1'b0;
      supply_s2_r <= 1'b0;
    end else begin
      supply_s1_r <= supply_low;
      supply_s2_r <= supply_s1_r;
    end
  end

  // Recovery timer after leaving power-down; it reloads all through
  // power-down, so the count only starts on the way out
  always_ff @(posedge clk) begin
    if (rst) begin
      recov_r <= '0;
    end else if (mode_nxt != MODE_NORMAL) begin
      recov_r <= supply_s2_r ? RECOV_3V_LD : RECOV_5V_LD;
    end else if (recov_r != '0) begin
      recov_r <= recov_r - 1'b1;
    end
  end

  // Valid only with the amplifier up and recovered
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_r <= 1'b1;
    end else begin
      out_valid_r <= (mode_nxt == MODE_NORMAL) &&
                     (recov_r == '0);
    end
  end

  // One-cycle pulse per executed word
  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_r <= 1'b0;
    end else begin
      loaded_r <= new_word;
    end
  end

  assign code_out    = code_r;
  assign mode_out    = mode_r;
  assign amp_on      = amp_on_r;
  assign term_1k     = term_1k_r;
  assign term_100k   = term_100k_r;
  assign out_hiz     = out_hiz_r;
  assign out_valid   = out_valid_r;
  assign word_loaded = loaded_r;

endmodule : dsl_dev

// ==== verif/dsl_link_monitor.sv ====
`timescale 1ns/1ps
module dsl_link_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_sclk_idle; sync_n |-> sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("shift clock low outside a frame");

  property p_setup; $fell(sync_n) |-> sclk [*4]; endproperty
  a_setup: assert property (p_setup)
    else $error("shift clock fell too soon after select");

  property p_fall_in_frame; $fell(sclk) |-> !sync_n; endproperty
  a_fall_in_frame: assert property (p_fall_in_frame)
    else $error("shift clock edge outside a frame");

  // Data may only move while the clock is high or in the same cycle as the capture edge
  property p_din_stable; !sclk && !$past(sclk) |-> $stable(din); endproperty
  a_din_stable: assert property (p_din_stable)
    else $error("data changed while shift clock low");

  property p_sclk_low; $fell(sclk) |-> !sclk [*4]; endproperty
  a_sclk_low: assert property (p_sclk_low)
    else $error("shift clock low phase too short");

  property p_sclk_high; $rose(sclk) |-> sclk [*4]; endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("shift clock high phase too short");

  property p_sync_gap; $rose(sync_n) |-> sync_n [*7]; endproperty
  a_sync_gap: assert property (p_sync_gap)
    else $error("select high time too short");

  property p_rise_clk_high; $rose(sync_n) |-> $past(sclk); endproperty
  a_rise_clk_high: assert property (p_rise_clk_high)
    else $error("select rose while shift clock low");
endmodule : dsl_link_monitor

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  import dsl_pkg::*;
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [CNT_W-1:0]  len;
    logic [CODE_W-1:0] code;
    logic [MODE_W-1:0] mode;
  } dsl_row_t;

  logic              clk = 1'b0;
  logic              rst;
  logic              req_valid;
  logic [WORD_W-1:0] req_word;
  logic [CNT_W-1:0]  req_len;
  logic              req_ready;
  logic              supply_low;
  logic [CODE_W-1:0] code_out;
  logic [MODE_W-1:0] mode_out;
  logic              amp_on;
  logic              term_1k;
  logic              term_100k;
  logic              out_hiz;
  logic              out_valid;
  logic              word_loaded;
  logic [3:0]        loads = 4'h0;
  logic [11:0]       since_load = 12'h000;
  int                fails = 0;
  int                checks = 0;
  // Power-down rows carry the running code 5A5 in their code bits, so only the mode moves
  dsl_row_t rows [7] = '{
    '{16'hC5A5, 5'h10, 12'h5A5, MODE_NORMAL},
    '{16'h15A5, 5'h10, 12'h5A5, MODE_PD_1K},
    '{16'h25A5, 5'h10, 12'h5A5, MODE_PD_100K},
    '{16'h35A5, 5'h10, 12'h5A5, MODE_PD_HIZ},
    '{16'h0ABC, 5'h08, 12'h5A5, MODE_PD_HIZ},
    '{16'h0800, 5'h00, 12'h800, MODE_NORMAL},
    '{16'h3FFF, 5'h0F, 12'h800, MODE_NORMAL}
  };

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    since_load <= (word_loaded === 1'b1) ? 12'h000 : since_load + 12'h001;
    if (word_loaded === 1'b1) begin
      loads <= loads + 4'h1;
    end
  end

  dsl_link_if lnk ();
  dsl_host u_dsl_host (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_word(req_word), .req_len(req_len), .req_ready(req_ready), .lnk(lnk));
  dsl_dev u_dsl_dev (.clk(clk), .rst(rst), .supply_low(supply_low),
    .lnk(lnk), .code_out(code_out), .mode_out(mode_out), .amp_on(amp_on),
    .term_1k(term_1k), .term_100k(term_100k), .out_hiz(out_hiz),
    .out_valid(out_valid), .word_loaded(word_loaded));
  dsl_link_monitor u_dsl_link_monitor (.clk(clk), .rst(rst),
    .sync_n(lnk.sync_n), .sclk(lnk.sclk), .din(lnk.din));

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_code(input logic [CODE_W-1:0] e,
                          input logic [CODE_W-1:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected code at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk_code

  task automatic chk_mode(input logic [MODE_W-1:0] e,
                          input logic [MODE_W-1:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected mode at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk_mode

  task automatic chk_flags(input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected flags at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk_flags

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_for(input logic want_valid, input int lim);
    int n;
    n = 0;
    while ((want_valid ? out_valid : req_ready) !== 1'b1) begin
      tick(1);
      n++;
      if (n > lim) begin
        fails++;
        end_of_test();
      end
    end
  endtask : wait_for

  task automatic send(input logic [WORD_W-1:0] w, input logic [CNT_W-1:0] l);
    wait_for(1'b0, 400);
    req_word = w;
    req_len = l;
    req_valid = 1'b1;
    tick(1);
    req_valid = 1'b0;
    tick(2);
    wait_for(1'b0, 400);
    tick(10);
  endtask : send

  task automatic check_row(input logic [CODE_W-1:0] c,
                           input logic [MODE_W-1:0] m);
    chk_code(c, code_out);
    chk_mode(m, mode_out);
    chk_flags(4'h8 >> m, {amp_on, term_1k, term_100k, out_hiz});
  endtask : check_row

  task automatic recov(input logic sl, input int cyc);
    send(16'h1800, 5'h10);
    supply_low = sl;
    send(16'h0800, 5'h10);
    chk_flags(4'h0, {3'h0, out_valid});
    wait_for(1'b1, 1200);
    chk_flags(4'h1, {3'h0, (since_load >= cyc - 5 &&
                            since_load <= cyc + 5)});
  endtask : recov

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_word = 16'h0000;
    req_len = 5'h00;
    supply_low = 1'b0;
    tick(10);
    rst = 1'b0;
    check_row(CODE_RESET, MODE_RESET);
    chk_flags(4'h1, {3'h0, out_valid});
    foreach (rows[i]) begin
      send(rows[i].word, rows[i].len);
      check_row(rows[i].code, rows[i].mode);
    end
    chk_flags(4'h5, loads);
    recov(1'b0, RECOV_5V_CYC);
    recov(1'b1, RECOV_3V_CYC);
    send(16'h3123, 5'h10);
    check_row(12'h123, MODE_PD_HIZ);
    rst = 1'b1;
    tick(10);
    rst = 1'b0;
    check_row(CODE_RESET, MODE_RESET);
    end_of_test();
  end
endmodule : tb
